// ### rtl/hmdp_pkg.sv
// Notes on behaviour
// - top bit clear: address plus memory selector
// - top bit set: overlay latched, host zeroes 14:8
// - latch strobe falling edge captures start address
// - address increments after every data access and after the second phase of a program word; a processor write to 0x3fe0 or 0x3fe7 that cycle blocks it
// - one cycle synchronising, one cycle accessing
// - control registers unreachable through the port
// - one 16-bit shared bus, 24-bit program words
// - port asynchronous, accepted at full speed
// - registers at 0x3fe0/0x3fe7, not host readable
// - processor may write the start address
// - overlay bit 14 selects short-read timing
// - mode pins 1-0-1 select port booting
// - execution held until program word zero written
// - reset empties stacks, mode status reads zero; interrupts masked only during boot hold
// - after boot, fetch starts at location zero
// - mode pins sampled in reset, then frozen
package hmdp_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [13:0] HMDP_START_ADDR_OFS = 14'h3fe0;
  localparam logic [13:0] HMDP_OVERLAY_OFS    = 14'h3fe7;
  localparam logic [13:0] HMDP_CTRL_BASE      = 14'h3fc0;
  localparam int          HMDP_SEL_BIT        = 14;
  localparam int          HMDP_TOP_BIT        = 15;
  localparam int          HMDP_SHORT_RD_BIT   = 14;
  localparam logic [15:0] HMDP_START_RST      = 16'h0000;
  localparam logic [15:0] HMDP_OVERLAY_RST    = 16'h0000;
  localparam logic [2:0]  HMDP_BOOT_MODE      = 3'h5;

  // ----------------------------------------
  // memory sizes and timing
  // ----------------------------------------
  localparam int          HMDP_AW             = 14;
  localparam int          HMDP_PW             = 24;
  localparam int          HMDP_DW             = 16;
  localparam int          HMDP_PWRUP_CLKS     = 2000;

  typedef enum logic [1:0]
  {
    HMDP_IDLE = 2'b00,
    HMDP_SYNC = 2'b01,
    HMDP_ACC  = 2'b10,
    HMDP_DONE = 2'b11
  } hmdp_state_t;

  typedef struct packed
  {
    logic        is_prog;
    logic [13:0] addr;
  } hmdp_addr_t;

endpackage

// ### rtl/hmdp_mem.sv
`timescale 1ns/1ns
`default_nettype none
module hmdp_mem
  import hmdp_pkg::*;
#(
  parameter int WIDTH = 24
)
(
  // clock
  input  wire logic                I_CORE_CLK,
  // port
  input  wire logic                i_we,
  input  wire logic [HMDP_AW-1:0]  i_addr,
  input  wire logic [WIDTH-1:0]    i_wdata,
  output logic      [WIDTH-1:0]    o_rdata
);
  logic [WIDTH-1:0] mem [0:(1<<HMDP_AW)-1];

  always_ff @(posedge I_CORE_CLK)
  begin
    if (i_we)
    begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule
`default_nettype wire

// ### rtl/hmdp_port.sv
`timescale 1ns/1ns
`default_nettype none
module hmdp_port
  import hmdp_pkg::*;
(
  // clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_NRST,
  // host pins
  input  wire logic [15:0] I_BUS,
  output logic      [15:0] O_BUS,
  output logic             O_BUS_OE,
  input  wire logic        I_SEL_N,
  input  wire logic        I_LATCH,
  input  wire logic        I_RD_N,
  input  wire logic        I_WR_N,
  output logic             O_ACK_N,
  // boot mode pins
  input  wire logic [2:0]  I_MODE,
  // processor data-memory register access
  input  wire logic        I_CPU_WE,
  input  wire logic [13:0] I_CPU_ADDR,
  input  wire logic [15:0] I_CPU_WDATA,
  output logic      [15:0] O_CPU_RDATA,
  // processor status
  output logic             O_RUN,
  output logic             O_FETCH_ZERO,
  output logic             O_SHORT_RD_TIMING,
  output logic             O_STACK_EMPTY,
  output logic             O_IRQ_MASKED,
  output logic      [15:0] O_MODE_STATUS
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // third stage lets a change count only when stages two and three agree
  logic [2:0] sel_s, lat_s, rd_s, wr_s;
  logic       sel_q, lat_q, rd_q, wr_q, lat_prev;
  logic [15:0] bus_s1, bus_s2;

  always_ff @(posedge I_CORE_CLK)
  begin
    sel_s  <= {sel_s[1:0], ~I_SEL_N};
    lat_s  <= {lat_s[1:0], I_LATCH};
    rd_s   <= {rd_s[1:0], ~I_RD_N};
    wr_s   <= {wr_s[1:0], ~I_WR_N};
    bus_s1 <= I_BUS;
    bus_s2 <= bus_s1;
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_NRST)
    begin
      sel_q    <= 1'b0;
      lat_q    <= 1'b0;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
      lat_prev <= 1'b0;
    end
    else
    begin
      if (sel_s[1] == sel_s[2]) sel_q <= sel_s[2];
      if (lat_s[1] == lat_s[2]) lat_q <= lat_s[2];
      if (rd_s[1] == rd_s[2])   rd_q  <= rd_s[2];
      if (wr_s[1] == wr_s[2])   wr_q  <= wr_s[2];
      lat_prev <= lat_q;
    end
  end

  // ----------------------------------------
  // mode capture
  // ----------------------------------------
  logic       boot_r;
  logic       held_r;
  logic [2:0] mode_r;

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_NRST)
    begin
      mode_r <= I_MODE;
    end
  end

  assign boot_r = (mode_r == HMDP_BOOT_MODE);

  // ----------------------------------------
  // address and overlay registers
  // ----------------------------------------
  hmdp_addr_t  addr_r;
  logic [15:0] ovl_r;
  hmdp_state_t st_r, st_nxt;
  logic        is_wr_r;
  logic        lat_fall;
  logic        acc_go;
  logic        done;
  logic        prog_phase_r;

  assign lat_fall = lat_prev & ~lat_q & sel_q;
  assign done     = (st_r == HMDP_ACC);

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_NRST)
    begin
      addr_r <= HMDP_START_RST[14:0];
      ovl_r  <= HMDP_OVERLAY_RST;
    end
    else if (lat_fall)
    begin
      if (bus_s2[HMDP_TOP_BIT])
      begin
        ovl_r <= {8'h00, bus_s2[7:0]};
      end
      else
      begin
        addr_r.is_prog <= bus_s2[HMDP_SEL_BIT];
        addr_r.addr  <= bus_s2[13:0];
      end
    end
    else if (I_CPU_WE && I_CPU_ADDR == HMDP_START_ADDR_OFS)
    begin
      addr_r.is_prog <= I_CPU_WDATA[HMDP_SEL_BIT];
      addr_r.addr  <= I_CPU_WDATA[13:0];
    end
    else if (I_CPU_WE && I_CPU_ADDR == HMDP_OVERLAY_OFS)
    begin
      ovl_r <= I_CPU_WDATA;
    end
    else if (done && (!addr_r.is_prog || !prog_phase_r))
    begin
      addr_r.addr <= addr_r.addr + 14'h0001;
    end
  end

  assign O_SHORT_RD_TIMING = ovl_r[HMDP_SHORT_RD_BIT];

  // both readable only over the processor path
  always_comb
  begin
    if (I_CPU_ADDR == HMDP_START_ADDR_OFS)
    begin
      O_CPU_RDATA = {1'b0, addr_r.is_prog, addr_r.addr};
    end
    else if (I_CPU_ADDR == HMDP_OVERLAY_OFS)
    begin
      O_CPU_RDATA = ovl_r;
    end
    else
    begin
      O_CPU_RDATA = 16'h0000;
    end
  end

  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  assign acc_go = sel_q & (rd_q | wr_q);

  // sync cycle, then one access cycle
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      HMDP_IDLE: if (acc_go) st_nxt = HMDP_SYNC;
      HMDP_SYNC: st_nxt = HMDP_ACC;
      HMDP_ACC:  st_nxt = HMDP_DONE;
      HMDP_DONE: if (!acc_go) st_nxt = HMDP_IDLE;
      default:   st_nxt = HMDP_IDLE;
    endcase
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_NRST)
    begin
      st_r    <= HMDP_IDLE;
      is_wr_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      if (st_r == HMDP_IDLE && acc_go) is_wr_r <= wr_q;
    end
  end

  // ----------------------------------------
  // memories
  // ----------------------------------------
  // program words are 24 bits: two data phases, high 16 then low 8
  logic [15:0]        prog_hi_r;
  logic               prog_we, data_we, ctl_hit;
  logic [HMDP_PW-1:0] prog_rd;
  logic [HMDP_DW-1:0] data_rd;
  logic [15:0]        rd_data_r;

  assign ctl_hit = ~addr_r.is_prog & (addr_r.addr >= HMDP_CTRL_BASE);
  assign prog_we = done & is_wr_r & addr_r.is_prog & ~prog_phase_r;
  assign data_we = done & is_wr_r & ~addr_r.is_prog & ~ctl_hit;

  hmdp_mem #(.WIDTH(HMDP_PW)) u_prog
  (
    .I_CORE_CLK (I_CORE_CLK),
    .i_we       (prog_we),
    .i_addr     (addr_r.addr),
    .i_wdata    ({prog_hi_r, bus_s2[7:0]}),
    .o_rdata    (prog_rd)
  );

  hmdp_mem #(.WIDTH(HMDP_DW)) u_data
  (
    .I_CORE_CLK (I_CORE_CLK),
    .i_we       (data_we),
    .i_addr     (addr_r.addr),
    .i_wdata    (bus_s2),
    .o_rdata    (data_rd)
  );

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_NRST)
    begin
      prog_phase_r <= 1'b0;
      prog_hi_r    <= 16'h0000;
      rd_data_r    <= 16'h0000;
    end
    else if (lat_fall)
    begin
      prog_phase_r <= 1'b0;
    end
    else if (st_r == HMDP_SYNC && addr_r.is_prog)
    begin
      if (!prog_phase_r && is_wr_r) prog_hi_r <= bus_s2;
      rd_data_r <= prog_phase_r ? {8'h00, prog_rd[7:0]} : prog_rd[23:8];
      prog_phase_r <= ~prog_phase_r;
    end
    else if (st_r == HMDP_SYNC)
    begin
      rd_data_r <= ctl_hit ? 16'h0000 : data_rd;
    end
  end

  assign O_BUS    = rd_data_r;
  assign O_BUS_OE = (st_r == HMDP_DONE) & ~is_wr_r & sel_q & rd_q;
  assign O_ACK_N  = ~((st_r == HMDP_IDLE) | (st_r == HMDP_DONE));

  // ----------------------------------------
  // boot hold and core reset state
  // ----------------------------------------
  // only the second phase completes a program word
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_NRST)
    begin
      held_r <= 1'b1;
    end
    else if (prog_we && addr_r.addr == 14'h0000)
    begin
      held_r <= 1'b0;
    end
  end

  assign O_RUN         = ~boot_r | ~held_r;
  assign O_FETCH_ZERO  = O_RUN;
  assign O_STACK_EMPTY = ~I_NRST | ~O_RUN;
  assign O_IRQ_MASKED  = ~O_RUN;
  assign O_MODE_STATUS = 16'h0000;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_sync_then_acc;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    (st_r == HMDP_SYNC) |=> (st_r == HMDP_ACC);
  endproperty
  a_sync_then_acc: assert property (p_sync_then_acc)
    else $error("sync not followed by access");

  property p_incr;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    (done && !lat_fall && !I_CPU_WE && (!addr_r.is_prog || !prog_phase_r))
      |=> (addr_r.addr == $past(addr_r.addr) + 14'h0001);
  endproperty
  a_incr: assert property (p_incr)
    else $error("address not incremented");

  property p_ctl_nowrite;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    ctl_hit |-> !data_we;
  endproperty
  a_ctl_nowrite: assert property (p_ctl_nowrite)
    else $error("control register written");

  property p_latch_addr;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    (lat_fall && !bus_s2[15]) |=> (addr_r.addr == $past(bus_s2[13:0]));
  endproperty
  a_latch_addr: assert property (p_latch_addr)
    else $error("start address not latched");

  property p_latch_ovl;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    (lat_fall && bus_s2[15]) |=> (ovl_r[7:0] == $past(bus_s2[7:0]));
  endproperty
  a_latch_ovl: assert property (p_latch_ovl)
    else $error("overlay not latched");

  property p_hold;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    (boot_r && $rose(O_RUN)) |-> ($past(prog_we) && $past(addr_r.addr) == 14'h0000);
  endproperty
  a_hold: assert property (p_hold)
    else $error("ran before location zero");

  property p_short;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    (I_CPU_WE && I_CPU_ADDR == HMDP_OVERLAY_OFS && !lat_fall)
      |=> (O_SHORT_RD_TIMING == $past(I_CPU_WDATA[HMDP_SHORT_RD_BIT]));
  endproperty
  a_short: assert property (p_short)
    else $error("timing select wrong");

  property p_mode_fixed;
    @(posedge I_CORE_CLK) disable iff (!I_NRST)
    1'b1 |=> $stable(mode_r);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed)
    else $error("mode changed while running");

endmodule
`default_nettype wire

// ### verification/hmdp_host.sv
`timescale 1ns/1ns
`default_nettype none
module hmdp_host
  import hmdp_pkg::*;
(
  // clock
  input  wire logic        i_clk,
  // host pins
  input  wire logic [15:0] i_bus,
  input  wire logic        i_ack_n,
  output logic      [15:0] o_bus,
  output logic             o_sel_n,
  output logic             o_latch,
  output logic             o_rd_n,
  output logic             o_wr_n
);
  int ack_cycles;
  initial
  begin
    o_bus   = 16'h0;
    o_sel_n = 1'b1;
    o_latch = 1'b0;
    o_rd_n  = 1'b1;
    o_wr_n  = 1'b1;
  end
  // bounded, so a stuck port cannot hang the host
  task automatic wait_ack();
    @(posedge i_clk);
    for (int n = 0; n < 20 && i_ack_n !== 1'b0; n++)
      @(posedge i_clk);
  endtask
  task automatic latch(input logic [15:0] v);
    wait_ack();
    o_sel_n <= 1'b0;
    o_latch <= 1'b1;
    o_bus   <= v;
    repeat (5) @(posedge i_clk);
    o_latch <= 1'b0;
    repeat (5) @(posedge i_clk);
    o_sel_n <= 1'b1;
    o_bus   <= ~v;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic access(input logic wr, input logic [15:0] d, output logic [15:0] q);
    wait_ack();
    o_sel_n <= 1'b0;
    o_rd_n  <= wr;
    o_wr_n  <= !wr;
    o_bus   <= wr ? d : ~o_bus;
    for (int n = 0; n < 20 && i_ack_n !== 1'b1; n++)
      @(posedge i_clk);
    ack_cycles = 0;
    while (i_ack_n === 1'b1 && ack_cycles < 20)
    begin
      @(posedge i_clk);
      ack_cycles++;
    end
    q = i_bus;
    o_sel_n <= 1'b1;
    o_rd_n  <= 1'b1;
    o_wr_n  <= 1'b1;
    o_bus   <= ~o_bus;
    repeat (4) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// ### verification/tb_host_memory_dma_port.sv
`timescale 1ns/1ns
`default_nettype none
module tb_host_memory_dma_port
  import hmdp_pkg::*;
;
  // ----------------------------------------
  // pins
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [2:0]  mode = 3'h5;
  logic        cpu_we = 1'b0;
  logic [13:0] cpu_addr = 14'h0;
  logic [15:0] cpu_wdata = 16'h0;
  logic [15:0] dut_bus, host_bus, q, cpu_rdata, mode_status_register;
  logic        oe, sel_n, lat, rd_n, wr_n, ack_n, run, fz, srt, se, im;
  wire  logic [15:0] bus_w;
  logic [31:0] rng = 32'h62;
  logic [15:0] d [6];
  logic [13:0] a;
  logic [23:0] w;
  int          mismatches = 0;
  int          tests_run = 0;

  always #5 clk = ~clk;
  // the port drives the shared bus only while answering a read
  assign bus_w = oe ? dut_bus : host_bus;

  hmdp_port DUT (.I_CORE_CLK(clk), .I_NRST(nrst), .I_BUS(bus_w), .O_BUS(dut_bus), .O_BUS_OE(oe),
    .I_SEL_N(sel_n), .I_LATCH(lat), .I_RD_N(rd_n), .I_WR_N(wr_n), .O_ACK_N(ack_n), .I_MODE(mode),
    .I_CPU_WE(cpu_we), .I_CPU_ADDR(cpu_addr), .I_CPU_WDATA(cpu_wdata), .O_CPU_RDATA(cpu_rdata),
    .O_RUN(run), .O_FETCH_ZERO(fz), .O_SHORT_RD_TIMING(srt), .O_STACK_EMPTY(se),
    .O_IRQ_MASKED(im), .O_MODE_STATUS(mode_status_register));
  hmdp_host host (.i_clk(clk), .i_bus(bus_w), .i_ack_n(ack_n), .o_bus(host_bus),
    .o_sel_n(sel_n), .o_latch(lat), .o_rd_n(rd_n), .o_wr_n(wr_n));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // overlay latch keeps only the low byte
  function automatic logic [15:0] ovl_exp(input logic [15:0] v);
    return {8'h00, v[7:0]};
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cpu_wr(input logic [13:0] ad, input logic [15:0] v);
    @(posedge clk);
    cpu_we    <= 1'b1;
    cpu_addr  <= ad;
    cpu_wdata <= v;
    @(posedge clk);
    cpu_we <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    check(ack_n, 1'b0);
    check(oe, 1'b0);
    check({se, im}, 2'h3);
    check(mode_status_register, 16'h0);
    check(run, 1'b0);
    mode <= 3'h0; // pins move after reset release, core still held
    rng = xs(rng);
    a = {1'b0, rng[12:0]};
    host.latch({2'b00, a});
    for (int i = 0; i < 6; i++)
    begin
      rng = xs(rng);
      d[i] = rng[15:0];
      host.access(1'b1, d[i], q);
      check(24'(host.ack_cycles), 24'h2);
    end
    host.latch({2'b00, a});
    for (int i = 0; i < 6; i++)
    begin
      host.access(1'b0, 16'h0, q);
      check(q, d[i]);
    end
    cpu_wr(HMDP_START_ADDR_OFS, {2'b00, a + 14'h2});
    host.access(1'b0, 16'h0, q);
    check(q, d[2]);
    host.latch({2'b00, HMDP_OVERLAY_OFS});
    host.access(1'b1, 16'h4000, q);
    check(srt, 1'b0);
    host.latch({2'b00, HMDP_START_ADDR_OFS});
    host.access(1'b0, 16'h0, q);
    check(q, 16'h0);
    rng = xs(rng);
    host.latch({8'h80, rng[7:0]});
    cpu_addr <= HMDP_OVERLAY_OFS;
    @(posedge clk);
    check(cpu_rdata, ovl_exp(rng[15:0]));
    cpu_wr(HMDP_OVERLAY_OFS, 16'h4000);
    check(srt, 1'b1);
    cpu_wr(HMDP_OVERLAY_OFS, 16'h0);
    check(srt, 1'b0);
    rng = xs(rng);
    w = rng[23:0];
    a = 14'h10 + {10'h0, rng[27:24]};
    host.latch({2'b01, a});
    host.access(1'b1, w[23:8], q);
    host.access(1'b1, {8'h00, w[7:0]}, q);
    check(run, 1'b0);
    host.latch({2'b01, a});
    host.access(1'b0, 16'h0, q);
    check(q, w[23:8]);
    host.access(1'b0, 16'h0, q);
    check(q[7:0], w[7:0]);
    host.latch(16'h4000);
    host.access(1'b1, w[23:8], q);
    check(run, 1'b0);
    host.access(1'b1, {8'h00, w[7:0]}, q);
    check({run, fz}, 2'h3);
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    check(run, 1'b1);
    check(mode_status_register, 16'h0);
    close_out();
  end

  initial
  begin
    // the sequence needs about four hundred cycles; this leaves wide slack
    #100000;
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
